/* File: design/icc_top.sv */
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Input capture channels with Wishbone register access
// ----------------------------------------------------------------------------

module icc_top #(
  parameter int NUM_CH = icc_pkg::NUM_CH,
  parameter int ADR_W  = icc_pkg::ADR_W
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Shared timebase counts
  input  wire logic [15:0]       timebase_first_count,
  input  wire logic [15:0]       timebase_second_count,
  // Processor power state
  input  wire logic              cpu_idle,
  input  wire logic              cpu_sleep,
  // Capture pins
  input  wire logic [NUM_CH-1:0] capture_input_pin,
  // Requests
  output logic      [NUM_CH-1:0] irq_req,
  output logic      [1:0]        dma_req,
  output logic                   wake_req
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  localparam int WIDX_W = ADR_W - 2;
  localparam int CH_W   = WIDX_W - icc_pkg::CH_IDX_SH;

  logic              ack_ff;
  logic [31:0]       dat_ff;
  logic              wake_ff;
  logic [NUM_CH-1:0] irq_ff;
  logic [1:0]        dma_ff;

  logic              req_go;
  logic [WIDX_W-1:0] word_idx;
  logic [CH_W-1:0]   ch_sel;
  logic              is_buf;
  logic              mapped;
  logic [31:0]       nxt_dat;
  logic              nxt_wake;

  logic [15:0]       ctl_view [NUM_CH];
  logic [15:0]       buf_view [NUM_CH];
  logic [NUM_CH-1:0] ctl_we;
  logic [NUM_CH-1:0] buf_pop;
  logic [NUM_CH-1:0] edge_any;
  logic [NUM_CH-1:0] irq_evt;

  // --------------------------------------------------------------------------
  // Wishbone decode
  // --------------------------------------------------------------------------

  // Request taken once, ack follows next edge
  assign req_go   = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign word_idx = wb_adr_i[ADR_W-1:2];
  assign ch_sel   = word_idx[WIDX_W-1:icc_pkg::CH_IDX_SH];
  assign is_buf   = (word_idx[0] == icc_pkg::REG_BUF_IDX);
  assign mapped   = ({1'b0, ch_sel} < (CH_W+1)'(NUM_CH));

  // Read data select, zero for unmapped
  always_comb begin
    nxt_dat = 32'h0000_0000;
    for (int i = 0; i < NUM_CH; i++) begin
      if (mapped && ({1'b0, ch_sel} == (CH_W+1)'(i))) begin
        nxt_dat = is_buf ? {16'h0000, buf_view[i]} : {16'h0000, ctl_view[i]};
      end
    end
  end

  // Acknowledge and read data registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req_go;
      if (req_go && !wb_we_i) begin
        dat_ff <= nxt_dat;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // --------------------------------------------------------------------------
  // Per-channel logic
  // --------------------------------------------------------------------------
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch

    logic        idle_halt_ff;
    logic        tsel_ff;
    logic [1:0]  cpi_ff;
    logic [2:0]  mode_ff;
    logic        ov_ff;
    logic [15:0] fifo_ff [icc_pkg::FIFO_DEPTH];
    logic [2:0]  wr_ptr_ff;
    logic [2:0]  rd_ptr_ff;
    logic [1:0]  irq_cnt_ff;
    logic [2:0]  fill;
    logic        full;
    logic        empty;
    logic        chan_off;
    logic        store;
    logic [15:0] tb_sample;
    logic [15:0] wdata;

    icc_evt_if evt ();

    // Edge detector for this pin
    icc_edge u_edge (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .pin      (capture_input_pin[ch]),
      .evt      (evt.det)
    );

    // Run unless halted by idle or sleeping
    assign evt.mode = mode_ff;
    assign evt.run  = ~cpu_sleep & ~(cpu_idle & idle_halt_ff);

    // Bus strobes for this channel
    assign ctl_we[ch]  = req_go & wb_we_i & mapped & ~is_buf
                       & ({1'b0, ch_sel} == (CH_W+1)'(ch));
    assign buf_pop[ch] = req_go & ~wb_we_i & mapped & is_buf
                       & ({1'b0, ch_sel} == (CH_W+1)'(ch));

    // FIFO status
    assign fill     = wr_ptr_ff - rd_ptr_ff;
    assign full     = (fill == 3'(icc_pkg::FIFO_DEPTH));
    assign empty    = (fill == 3'h0);
    assign chan_off = (mode_ff == icc_pkg::ICC_MODE_OFF);
    assign store    = evt.capture & ~full & ~chan_off;

    // Timebase choice
    assign tb_sample = tsel_ff ? timebase_first_count
                               : timebase_second_count;

    // Masked write data, byte lanes honoured
    assign wdata = {wb_sel_i[1] ? wb_dat_i[15:8] : ctl_view[ch][15:8],
                    wb_sel_i[0] ? wb_dat_i[7:0]  : ctl_view[ch][7:0]};

    // Writable control fields
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        idle_halt_ff <= icc_pkg::CTL_RESET[icc_pkg::IDLE_HALT_BIT];
        tsel_ff      <= icc_pkg::CTL_RESET[icc_pkg::TSEL_BIT];
        cpi_ff       <= icc_pkg::CTL_RESET[icc_pkg::CPI_LSB +: 2];
        mode_ff      <= icc_pkg::CTL_RESET[icc_pkg::MODE_LSB +: 3];
      end else if (ctl_we[ch]) begin
        idle_halt_ff <= wdata[icc_pkg::IDLE_HALT_BIT];
        tsel_ff      <= wdata[icc_pkg::TSEL_BIT];
        cpi_ff       <= wdata[icc_pkg::CPI_LSB +: 2];
        mode_ff      <= wdata[icc_pkg::MODE_LSB +: 3];
      end
    end

    // Overflow flag, cleared only by turning off
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        ov_ff <= 1'b0;
      end else if (chan_off) begin
        ov_ff <= 1'b0;
      end else if (evt.capture && full) begin
        ov_ff <= 1'b1;
      end
    end

    // FIFO write side
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        wr_ptr_ff <= 3'h0;
        for (int e = 0; e < icc_pkg::FIFO_DEPTH; e++) begin
          fifo_ff[e] <= 16'h0000;
        end
      end else if (chan_off) begin
        wr_ptr_ff <= 3'h0;
      end else if (store) begin
        fifo_ff[wr_ptr_ff[1:0]] <= tb_sample;
        wr_ptr_ff               <= wr_ptr_ff + 3'h1;
      end
    end

    // FIFO read side, pop on buffer read
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        rd_ptr_ff <= 3'h0;
      end else if (chan_off) begin
        rd_ptr_ff <= 3'h0;
      end else if (buf_pop[ch] && !empty) begin
        rd_ptr_ff <= rd_ptr_ff + 3'h1;
      end
    end

    // Captures since last interrupt
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        irq_cnt_ff <= 2'h0;
      end else if (chan_off) begin
        irq_cnt_ff <= 2'h0;
      end else if (store) begin
        irq_cnt_ff <= (irq_cnt_ff == cpi_ff) ? 2'h0 : irq_cnt_ff + 2'h1;
      end
    end

    // Interrupt event on the programmed count
    assign irq_evt[ch]  = store & (irq_cnt_ff == cpi_ff);
    assign edge_any[ch] = evt.edge_seen;

    // Register views
    assign buf_view[ch] = empty ? 16'h0000 : fifo_ff[rd_ptr_ff[1:0]];
    always_comb begin
      ctl_view[ch]                              = 16'h0000;
      ctl_view[ch][icc_pkg::IDLE_HALT_BIT]      = idle_halt_ff;
      ctl_view[ch][icc_pkg::TSEL_BIT]           = tsel_ff;
      ctl_view[ch][icc_pkg::CPI_LSB +: 2]       = cpi_ff;
      ctl_view[ch][icc_pkg::OV_BIT]             = ov_ff;
      ctl_view[ch][icc_pkg::BNE_BIT]            = ~empty;
      ctl_view[ch][icc_pkg::MODE_LSB +: 3]      = mode_ff;
    end
  end

  // --------------------------------------------------------------------------
  // Request outputs
  // --------------------------------------------------------------------------

  // Interrupt pulses, one per threshold
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ff <= '0;
    end else begin
      irq_ff <= irq_evt;
    end
  end

  // DMA pulses from the first two channels only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_ff <= 2'h0;
    end else begin
      dma_ff <= irq_evt[1:0];
    end
  end

  // Wake on any enabled pin edge in low power
  assign nxt_wake = (cpu_sleep | cpu_idle) & (|edge_any);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= nxt_wake;
    end
  end

  assign irq_req  = irq_ff;
  assign dma_req  = dma_ff;
  assign wake_req = wake_ff;

endmodule : icc_top

/* File: shared/icc_pkg.sv */
// ----------------------------------------------------------------------------
// Capture channel constants
// ----------------------------------------------------------------------------
package icc_pkg;

  // Block shape
  localparam int NUM_CH     = 8;
  localparam int DATA_W     = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int PTR_W      = 3;
  localparam int ADR_W      = 8;

  // Register word indices within a channel (byte address = 4 * index)
  localparam logic [0:0] REG_CTL_IDX = 1'h0;
  localparam logic [0:0] REG_BUF_IDX = 1'h1;
  localparam int         CH_IDX_SH   = 1;

  // Control register fields
  localparam int IDLE_HALT_BIT = 13;
  localparam int TSEL_BIT      = 7;
  localparam int CPI_LSB       = 5;
  localparam int OV_BIT        = 4;
  localparam int BNE_BIT       = 3;
  localparam int MODE_LSB      = 0;

  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] CTL_WMASK = 16'h20e7;

  // Mode field encodings
  typedef enum logic [2:0] {
    ICC_MODE_OFF    = 3'h0,
    ICC_MODE_EACH   = 3'h1,
    ICC_MODE_FALL   = 3'h2,
    ICC_MODE_RISE   = 3'h3,
    ICC_MODE_RISE4  = 3'h4,
    ICC_MODE_RISE16 = 3'h5
  } icc_mode_t;

  // Prescaler terminal counts
  localparam logic [3:0] PRESC_LAST4  = 4'h3;
  localparam logic [3:0] PRESC_LAST16 = 4'hf;

endpackage : icc_pkg

/* File: shared/icc_evt_if.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Control to edge detector link
// ----------------------------------------------------------------------------
interface icc_evt_if;
  logic [2:0] mode;
  logic       run;
  logic       capture;
  logic       edge_seen;

  modport ctl (output mode, output run, input capture, input edge_seen);
  modport det (input mode, input run, output capture, output edge_seen);
endinterface : icc_evt_if

/* File: design/icc_edge.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Pin synchroniser, edge detector and prescaler
// ----------------------------------------------------------------------------
module icc_edge (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Capture pin
  input  wire logic pin,
  // Control link
  icc_evt_if.det    evt
);

  logic       sync_a_ff;
  logic       sync_b_ff;
  logic       prev_ff;
  logic [3:0] presc_ff;
  logic [3:0] nxt_presc;
  logic       rise;
  logic       fall;

  // Two-stage synchroniser plus history
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a_ff <= 1'b0;
      sync_b_ff <= 1'b0;
      prev_ff   <= 1'b0;
    end else begin
      sync_a_ff <= pin;
      sync_b_ff <= sync_a_ff;
      prev_ff   <= sync_b_ff;
    end
  end

  assign rise = sync_b_ff & ~prev_ff;
  assign fall = ~sync_b_ff & prev_ff;

  // Wake source: any edge while enabled
  assign evt.edge_seen = (rise | fall) & (evt.mode != icc_pkg::ICC_MODE_OFF);

  // Prescaler next value and capture decision
  always_comb begin
    nxt_presc   = presc_ff;
    evt.capture = 1'b0;
    unique case (icc_pkg::icc_mode_t'(evt.mode))
      icc_pkg::ICC_MODE_OFF: begin
        nxt_presc = 4'h0;
      end
      icc_pkg::ICC_MODE_EACH: begin
        evt.capture = evt.run & (rise | fall);
      end
      icc_pkg::ICC_MODE_FALL: begin
        evt.capture = evt.run & fall;
      end
      icc_pkg::ICC_MODE_RISE: begin
        evt.capture = evt.run & rise;
      end
      icc_pkg::ICC_MODE_RISE4: begin
        if (evt.run && rise) begin
          evt.capture = (presc_ff[1:0] == icc_pkg::PRESC_LAST4[1:0]);
          nxt_presc   = {2'h0, presc_ff[1:0] + 2'h1};
        end
      end
      icc_pkg::ICC_MODE_RISE16: begin
        if (evt.run && rise) begin
          evt.capture = (presc_ff == icc_pkg::PRESC_LAST16);
          nxt_presc   = presc_ff + 4'h1;
        end
      end
      default: begin
        nxt_presc = 4'h0;
      end
    endcase
  end

  // Prescaler count of rising edges
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_ff <= 4'h0;
    end else begin
      presc_ff <= nxt_presc;
    end
  end

endmodule : icc_edge

/* File: bench/icc_pin_src.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Capture pin source
// ----------------------------------------------------------------------------
module icc_pin_src (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // Toggle requests, one bit per pin
  input  wire logic [7:0] tgl,
  // Driven pin levels
  output logic      [7:0] pin
);
  // Flip requested pins; each level then stands for whole cycles
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin <= 8'h00;
    end else begin
      pin <= pin ^ tgl;
    end
  end
endmodule : icc_pin_src

/* File: bench/icc_top_assertions.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------------
module icc_top_assertions #(
  parameter int NUM_CH = 8,
  parameter int ADR_W  = 8
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  // Wishbone
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [31:0]       wb_dat_o,
  input  wire logic              wb_ack_o,
  // Timebases and power state
  input  wire logic [15:0]       timebase_first_count,
  input  wire logic [15:0]       timebase_second_count,
  input  wire logic              cpu_idle,
  input  wire logic              cpu_sleep,
  // Pins and requests
  input  wire logic [NUM_CH-1:0] capture_input_pin,
  input  wire logic [NUM_CH-1:0] irq_req,
  input  wire logic [1:0]        dma_req,
  input  wire logic              wake_req
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // Bus answer timing
  AST_ACK_RESP:
    assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("no ack");
  AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ACK_CAUSE:
    assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  // Requests tied to their causes
  AST_DMA_EQ:
    assert property (dma_req == irq_req[1:0]) else $error("dma differs from irq");
  AST_SLEEP_BLOCK:
    assert property (|irq_req |-> !$past(cpu_sleep) && !$past(cpu_sleep, 2))
      else $error("irq in sleep");
  AST_WAKE_STATE:
    assert property (wake_req |-> $past(cpu_idle || cpu_sleep)) else $error("wake while running");
  AST_IRQ_PIN:
    assert property (|irq_req |-> ($past(capture_input_pin, 3) != $past(capture_input_pin, 4))
      || ($past(capture_input_pin, 4) != $past(capture_input_pin, 5))) else $error("irq no edge");
  AST_WAKE_PIN:
    assert property (wake_req |-> ($past(capture_input_pin, 3) != $past(capture_input_pin, 4))
      || ($past(capture_input_pin, 4) != $past(capture_input_pin, 5))) else $error("wake no edge");
endmodule : icc_top_assertions

bind icc_top icc_top_assertions #(.NUM_CH(NUM_CH), .ADR_W(ADR_W)) i_icc_top_assertions (
  .core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timebase_first_count(timebase_first_count),
  .timebase_second_count(timebase_second_count), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
  .capture_input_pin(capture_input_pin), .irq_req(irq_req), .dma_req(dma_req),
  .wake_req(wake_req));

/* File: bench/tb.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------------------
module tb;
  logic        core_clk, arst_n, cyc, stb, we_r, idle, sleep, ack, wake, ov;
  logic [7:0]  adr, tgl, pins, irq, pl;
  logic [3:0]  sel;
  logic [31:0] dat, dat_o;
  logic [15:0] tb1, tb2, ctlv, irq_n, wake_n, e_irq, e_wake;
  logic [1:0]  dma;
  logic [15:0] mq[$];
  logic [15:0] exp_q[$];
  int          ch, mode, tsel, cpi, ih, nr, st, fail_count, n_tests;
  int          seed = 5;

  icc_pin_src i_icc_pin_src (.core_clk(core_clk), .arst_n(arst_n), .tgl(tgl), .pin(pins));
  icc_top i_icc_top (.core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we_r), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .timebase_first_count(tb1), .timebase_second_count(tb2),
    .cpu_idle(idle), .cpu_sleep(sleep), .capture_input_pin(pins), .irq_req(irq),
    .dma_req(dma), .wake_req(wake));

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Classic single Wishbone cycle; reads note their expectation first
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                    input logic [15:0] e);
    int n;
    if (!w) exp_q.push_back(e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we_r <= w;
    adr <= a;
    dat <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      tally_and_finish();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask : wb

  task automatic rd_ctl();
    wb(1'b0, 8'(8 * ch), 16'h0000, ctlv | {11'h000, ov, mq.size() != 0, 3'h0});
  endtask : rd_ctl

  task automatic rd_buf();
    wb(1'b0, 8'(8 * ch + 4), 16'h0000, (mq.size() != 0) ? mq.pop_front() : 16'h0000);
  endtask : rd_buf

  // Off then new setting; model cleared like the channel
  task automatic set_ctl(input int m, input int t, input int k, input int h);
    wb(1'b1, 8'(8 * ch), 16'h0000, 16'h0000);
    mq.delete();
    ov = 1'b0;
    st = 0;
    nr = 0;
    mode = m;
    tsel = t;
    cpi = k;
    ih = h;
    ctlv = 16'((h << 13) | (t << 7) | (k << 5) | m);
    wb(1'b1, 8'(8 * ch), ctlv, 16'h0000);
  endtask : set_ctl

  // One pin transition with fresh timebase values, model updated
  task automatic tog();
    logic        cap;
    logic [15:0] t1, t2;
    t1 = 16'($random(seed));
    t2 = 16'($random(seed));
    tb1 <= t1;
    tb2 <= t2;
    tgl <= 8'h01 << ch;
    @(posedge core_clk);
    tgl <= 8'h00;
    // Power state taken after the caller's own updates have landed
    pl[ch] = !pl[ch];
    if (pl[ch]) nr++;
    cap = mode == 1 || (mode == 2 && !pl[ch]) || (mode == 3 && pl[ch])
      || (pl[ch] && ((mode == 4 && nr % 4 == 0) || (mode == 5 && nr % 16 == 0)));
    if (cap && (idle || sleep)) e_wake++;
    if (cap && !sleep && !(idle && ih == 1)) begin
      if (mq.size() < 4) begin
        mq.push_back(tsel == 1 ? t1 : t2);
        st++;
        if (st % (cpi + 1) == 0) e_irq++;
      end else begin
        ov = 1'b1;
      end
    end
    repeat (8) @(posedge core_clk);
  endtask : tog

  // Result watcher: read data against oldest note, request pulses counted
  always @(posedge core_clk) begin
    if (ack === 1'b1 && we_r === 1'b0 && exp_q.size() != 0) cmp(dat_o[15:0], exp_q.pop_front());
    if (ch < 8 && irq[ch] === 1'b1) irq_n <= irq_n + 16'h0001;
    if (wake === 1'b1) wake_n <= wake_n + 16'h0001;
  end

  initial begin
    {arst_n, cyc, stb, we_r, idle, sleep, ov, adr, tgl, pl, dat, tb1, tb2} = '0;
    {irq_n, wake_n, e_irq, e_wake, ctlv} = '0;
    sel = 4'h3;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    for (ch = 0; ch <= 8; ch++) rd_ctl();
    wb(1'b1, 8'h40, 16'hffff, 16'h0000);
    rd_ctl();
    ch = 2;
    wb(1'b1, 8'h10, 16'hffff, 16'h0000);
    wb(1'b0, 8'h10, 16'h0000, 16'h20e7);
    for (int m = 1; m <= 3; m++) begin
      for (int t = 0; t <= 1; t++) begin
        ch = m + 4 * t;
        set_ctl(m, t, 0, 0);
        repeat (4) tog();
        rd_ctl();
        repeat (5) rd_buf();
        rd_ctl();
      end
    end
    ch = 0;
    for (int m = 4; m <= 5; m++) begin
      set_ctl(m, 1, 0, 0);
      repeat (32) tog();
      repeat (3) rd_buf();
    end
    ch = 1;
    for (int k = 0; k <= 3; k++) begin
      set_ctl(3, 0, k, 0);
      repeat (10) tog();
      rd_ctl();
      repeat (5) rd_buf();
    end
    cmp(irq_n, e_irq);
    ch = 7;
    for (int h = 1; h >= 0; h--) begin
      set_ctl(3, 1, 0, h);
      idle <= 1'b1;
      tog();
      idle <= 1'b0;
      tog();
      rd_buf();
    end
    sleep <= 1'b1;
    tog();
    sleep <= 1'b0;
    tog();
    rd_buf();
    cmp(wake_n, e_wake);
    tally_and_finish();
  end
endmodule : tb
